// *** aptc_top.sv ***
// Converter digital control: pin disable, clock select, trigger, result placement.
// Assumes an Avalon-MM master, a raw result from the analog core and pins on port logic.
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module aptc_top (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Avalon-MM slave.
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Port logic and pins.
  input wire logic [23:0] port_oe_n_i,
  input wire logic [23:0] port_pullup_i,
  input wire logic [23:0] pin_in_i,
  output logic [23:0] pin_oe_n_o,
  output logic [23:0] pin_pullup_o,
  output logic [23:0] pin_ibuf_en_o,
  output logic [23:0] port_read_o,
  // Analog core.
  input wire logic [10:0] raw_result_i,
  input wire logic alt_tick_i,
  input wire logic hw_trigger_input_i,
  output logic conv_enable_o,
  output logic sample_o,
  output logic async_osc_on_o,
  output logic [4:0] channel_select_o,
  // Completion request.
  output logic irq_o
);
  logic [7:0] pin_reg [3];
  logic [7:0] ctrl1_reg;
  logic trg_reg, cmpen_reg, cmpgt_reg;
  logic [1:0] cmp_hi_reg;
  logic [7:0] cmp_lo_reg;
  logic [7:0] cfg_reg;
  logic [1:0] res_hi_reg;
  logic [7:0] res_lo_reg;
  logic lock_reg;
  logic seq_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [1:0] trg_sync_reg;
  logic trg_prev_reg;
  logic [5:0] tick_cnt_reg;
  logic [2:0] osc_reg;
  logic [23:0] pin_sync1_reg, pin_sync2_reg;
  aptc_pkg::aptc_state_e state_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. Every access takes one wait cycle, then completes.
  wire logic [3:0] idx = avs_address_i[5:2];
  wire logic req = avs_read_i || avs_write_i;
  wire logic wr = avs_write_i && ack_reg;
  wire logic rd = avs_read_i && ack_reg;
  wire logic wr_ctrl1 = wr && (idx == aptc_pkg::IDX_CTRL1);
  wire logic wr_cfgx = wr && (idx == aptc_pkg::IDX_CTRL2 || idx == aptc_pkg::IDX_CFG ||
                              idx == aptc_pkg::IDX_CMP_HI || idx == aptc_pkg::IDX_CMP_LO);
  wire logic rd_hi = rd && (idx == aptc_pkg::IDX_RES_HI);
  wire logic rd_lo = rd && (idx == aptc_pkg::IDX_RES_LO);
  assign avs_waitrequest_o = req && !ack_reg;
  assign avs_readdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin control.
  wire logic [23:0] pin_dis = {pin_reg[2], pin_reg[1], pin_reg[0]}; // [RULE1] [RULE2]
  assign pin_oe_n_o = port_oe_n_i | pin_dis; // [RULE3]
  assign pin_pullup_o = port_pullup_i & ~pin_dis; // [RULE3]
  assign pin_ibuf_en_o = ~pin_dis; // [RULE4]
  assign port_read_o = pin_sync2_reg & ~pin_dis; // [RULE4]

  ////////////////////////////////////////////////////////////////////////////
  // Converter control decode.
  wire logic [4:0] chan = ctrl1_reg[4:0];
  wire logic chan_off = (chan == aptc_pkg::CHAN_OFF); // [RULE5] [RULE21]
  wire logic [1:0] mode = cfg_reg[aptc_pkg::CFG_MODE_LSB +: 2];
  wire logic [1:0] src = cfg_reg[1:0];
  wire logic [1:0] div = cfg_reg[aptc_pkg::CFG_DIV_LSB +: 2];
  wire logic mode10 = (mode == aptc_pkg::MODE_10BIT); // [RULE20]
  wire logic busy = (state_reg == aptc_pkg::ST_CONV);
  wire logic cont = ctrl1_reg[aptc_pkg::CTRL1_CONT_BIT];
  wire logic trg_rise = trg_sync_reg[1] && !trg_prev_reg; // [RULE22]
  // Hardware edges count only when idle and not already in a continuous run.
  wire logic hw_start = trg_reg && trg_rise && !busy && !seq_reg && !chan_off; // [RULE15] [RULE16] [RULE17]
  wire logic sw_start = wr_ctrl1 && !trg_reg && (avs_writedata_i[4:0] != aptc_pkg::CHAN_OFF);
  wire logic async_tick = (osc_reg == aptc_pkg::ASYNC_OSC_DIV);
  wire logic conv_tick;
  wire logic [5:0] conv_len = mode10 ? aptc_pkg::CONV_TICKS_10 : aptc_pkg::CONV_TICKS_8;
  wire logic conv_end = busy && conv_tick && (tick_cnt_reg == 6'(conv_len - 6'h1));

  ////////////////////////////////////////////////////////////////////////////
  // Rounding and compare.
  wire logic [10:0] rnd10_sum = 11'(raw_result_i + 11'h1);
  wire logic [9:0] rnd10 = (raw_result_i[10:1] == 10'h3FF) ? 10'h3FF : rnd10_sum[10:1]; // [RULE7]
  wire logic [9:0] rnd9_sum = 10'(raw_result_i[8:0] + 9'h1);
  wire logic [7:0] rnd8 = (raw_result_i[8:1] == 8'hFF) ? 8'hFF : rnd9_sum[8:1]; // [RULE7]
  wire logic [9:0] result = mode10 ? rnd10 : {2'h0, rnd8};
  wire logic [9:0] cmp_val = mode10 ? {cmp_hi_reg, cmp_lo_reg} : {2'h0, cmp_lo_reg};
  wire logic [9:0] cmp_diff = 10'(result - cmp_val);
  wire logic cmp_ge = (result >= cmp_val);
  wire logic cmp_ok = !cmpen_reg || (cmpgt_reg ? cmp_ge : !cmp_ge); // [RULE9]
  wire logic [9:0] store_val = cmpen_reg ? cmp_diff : result; // [RULE9]
  wire logic blocked = mode10 && lock_reg;
  wire logic store = conv_end && cmp_ok && !blocked; // [RULE7] [RULE8]
  // A blocked transfer restarts, except a failed single compare which ends.
  wire logic restart = conv_end && !chan_off && (cont || (blocked && cmp_ok));

  aptc_clkdiv u_clkdiv (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .run_i(busy),
    .src_i(src),
    .div_i(div),
    .alt_tick_i(alt_tick_i),
    .async_tick_i(async_tick),
    .tick_o(conv_tick)
  );

  assign conv_enable_o = busy && !chan_off; // [RULE5] [RULE6]
  assign sample_o = conv_end;
  assign async_osc_on_o = busy && (src == aptc_pkg::SRC_ASYNC); // [RULE13]
  assign channel_select_o = chan;
  assign irq_o = ctrl1_reg[aptc_pkg::CTRL1_DONE_BIT] && ctrl1_reg[aptc_pkg::CTRL1_IEN_BIT]; // [RULE8]

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux.
  wire logic [7:0] ctrl2_rd = {busy, trg_reg, cmpen_reg, cmpgt_reg, 4'h0};
  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      aptc_pkg::IDX_PIN0: rd_byte = pin_reg[0];
      aptc_pkg::IDX_PIN1: rd_byte = pin_reg[1];
      aptc_pkg::IDX_PIN2: rd_byte = pin_reg[2];
      aptc_pkg::IDX_CTRL1: rd_byte = ctrl1_reg;
      aptc_pkg::IDX_CTRL2: rd_byte = ctrl2_rd;
      aptc_pkg::IDX_RES_HI: rd_byte = {6'h00, res_hi_reg};
      aptc_pkg::IDX_RES_LO: rd_byte = res_lo_reg;
      aptc_pkg::IDX_CMP_HI: rd_byte = {6'h00, cmp_hi_reg};
      aptc_pkg::IDX_CMP_LO: rd_byte = cmp_lo_reg;
      aptc_pkg::IDX_CFG: rd_byte = cfg_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake and synchronisers.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      trg_sync_reg <= 2'h0;
      trg_prev_reg <= 1'b0;
      pin_sync1_reg <= 24'h00_0000;
      pin_sync2_reg <= 24'h00_0000;
      osc_reg <= 3'h0;
    end else begin
      ack_reg <= req && !ack_reg;
      rdata_reg <= (req && !ack_reg) ? {24'h00_0000, rd_byte} : rdata_reg;
      trg_sync_reg <= {trg_sync_reg[0], hw_trigger_input_i}; // [RULE22]
      trg_prev_reg <= trg_sync_reg[1];
      pin_sync1_reg <= pin_in_i;
      pin_sync2_reg <= pin_sync1_reg;
      osc_reg <= async_tick ? 3'h0 : 3'(osc_reg + 3'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and conversion state.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_reg[0] <= 8'h00;
      pin_reg[1] <= 8'h00;
      pin_reg[2] <= 8'h00;
      ctrl1_reg <= aptc_pkg::CTRL1_RESET; // [RULE5]
      {trg_reg, cmpen_reg, cmpgt_reg} <= 3'h0;
      cmp_hi_reg <= 2'h0;
      cmp_lo_reg <= 8'h00;
      cfg_reg <= 8'h00; // [RULE10]
      res_hi_reg <= 2'h0;
      res_lo_reg <= 8'h00;
      lock_reg <= 1'b0;
      seq_reg <= 1'b0;
      tick_cnt_reg <= 6'h00;
      state_reg <= aptc_pkg::ST_OFF;
    end else begin
      if (wr && idx <= aptc_pkg::IDX_PIN2) begin
        pin_reg[idx[1:0]] <= avs_writedata_i[7:0]; // [RULE1] [RULE2]
      end
      if (wr && idx == aptc_pkg::IDX_CTRL2) begin
        trg_reg <= avs_writedata_i[aptc_pkg::CTRL2_TRG_BIT];
        cmpen_reg <= avs_writedata_i[aptc_pkg::CTRL2_CMPEN_BIT];
        cmpgt_reg <= avs_writedata_i[aptc_pkg::CTRL2_CMPGT_BIT];
      end
      if (wr && idx == aptc_pkg::IDX_CMP_HI) begin
        cmp_hi_reg <= avs_writedata_i[1:0];
      end
      if (wr && idx == aptc_pkg::IDX_CMP_LO) begin
        cmp_lo_reg <= avs_writedata_i[7:0];
      end
      if (wr && idx == aptc_pkg::IDX_CFG) begin
        cfg_reg <= avs_writedata_i[7:0];
      end
      // In 10-bit mode, reading the high byte locks results until the low byte is read.
      if (rd_hi && mode10) begin
        lock_reg <= 1'b1;
      end else if (rd_lo) begin
        lock_reg <= 1'b0;
      end
      if (store) begin
        res_hi_reg <= store_val[9:8];
        res_lo_reg <= store_val[7:0];
      end
      // Completion flag: set wins over clear by write or low-byte read.
      if (wr_ctrl1) begin
        ctrl1_reg[6:0] <= avs_writedata_i[6:0];
      end
      if (store) begin
        ctrl1_reg[aptc_pkg::CTRL1_DONE_BIT] <= 1'b1; // [RULE8]
      end else if (wr_ctrl1 || rd_lo) begin
        ctrl1_reg[aptc_pkg::CTRL1_DONE_BIT] <= 1'b0;
      end
      tick_cnt_reg <= (!busy || conv_end) ? 6'h00 : (conv_tick ? 6'(tick_cnt_reg + 6'h1) : tick_cnt_reg);
      case (state_reg)
        aptc_pkg::ST_OFF, aptc_pkg::ST_IDLE, aptc_pkg::ST_DONE: begin
          if (chan_off && !sw_start) begin
            seq_reg <= 1'b0;
            state_reg <= aptc_pkg::ST_OFF; // [RULE21]
          end else if (sw_start || hw_start) begin
            seq_reg <= sw_start ? avs_writedata_i[aptc_pkg::CTRL1_CONT_BIT] : cont;
            state_reg <= aptc_pkg::ST_CONV;
          end else begin
            state_reg <= aptc_pkg::ST_IDLE; // [RULE6]
          end
        end
        aptc_pkg::ST_CONV: begin
          if (wr_ctrl1 || wr_cfgx) begin
            seq_reg <= sw_start && avs_writedata_i[aptc_pkg::CTRL1_CONT_BIT];
            state_reg <= sw_start ? aptc_pkg::ST_CONV : aptc_pkg::ST_IDLE;
          end else if (chan_off) begin
            state_reg <= aptc_pkg::ST_OFF;
          end else if (conv_end && !restart) begin
            seq_reg <= 1'b0;
            state_reg <= aptc_pkg::ST_DONE; // [RULE6]
          end
        end
        default: state_reg <= aptc_pkg::ST_OFF;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** aptc_pkg.sv ***
// Package for the converter pin, clock and trigger control block.
// Assumes a 20 MHz bus clock and an Avalon-MM slave with byte-wide registers in the low bits of each word.
// Function
// RULE1: Three 8-bit pin-disable registers cover channels 0-7, 8-15 and 16-23.
// RULE2: Bit n controls channel n of its group; 1 disables port control.
// RULE3: A set pin-disable bit forces output high impedance and pullup off.
// RULE4: A set pin-disable bit disables the input buffer; port reads return zero.
// RULE5: Converter held disabled during reset and when channel select is all ones.
// RULE6: After completion and before a new start the converter sits idle.
// RULE7: Round 11-bit raw to 10 bits, or 9-bit raw to 8 bits low only.
// RULE8: Completion sets the complete flag; interrupt raised when enable is set.
// RULE9: Compare enable compares each result against compare registers in all modes.
// RULE10: Clock source select picks one of four sources; bus clock after reset.
// RULE11: Selected source divided by 1, 2, 4 or 8 for the converter clock.
// RULE12: Halved bus clock with divide by 8 gives division by 16.
// RULE13: Internal asynchronous clock comes from inside and runs in wait and stop.
// RULE14: Software keeps the converter clock in range by dividing fast sources.
// RULE15: With trigger select set, each rising hardware trigger edge starts a conversion.
// RULE16: A trigger edge during a conversion in progress is ignored.
// RULE17: In continuous mode only the first trigger edge launches the sequence.
// RULE18: Source codes 00 bus, 01 bus halved, 10 alternate clock.
// RULE19: Divide codes 00, 01, 10, 11 give 1, 2, 4, 8.
// RULE20: Mode code 00 is 8-bit, 10 is 10-bit; others reserved.
// RULE21: Channel select 11111 switches the converter off and isolates the input.
// RULE22: The hardware trigger is synchronised before rising-edge detection.
package aptc_pkg;
  // Register word offsets (byte address = 4 * index).
  localparam logic [3:0] IDX_PIN0 = 4'h0;
  localparam logic [3:0] IDX_PIN1 = 4'h1;
  localparam logic [3:0] IDX_PIN2 = 4'h2;
  localparam logic [3:0] IDX_CTRL1 = 4'h3;
  localparam logic [3:0] IDX_CTRL2 = 4'h4;
  localparam logic [3:0] IDX_RES_HI = 4'h5;
  localparam logic [3:0] IDX_RES_LO = 4'h6;
  localparam logic [3:0] IDX_CMP_HI = 4'h7;
  localparam logic [3:0] IDX_CMP_LO = 4'h8;
  localparam logic [3:0] IDX_CFG = 4'h9;
  // Control 1 fields.
  localparam int CTRL1_DONE_BIT = 7;
  localparam int CTRL1_IEN_BIT = 6;
  localparam int CTRL1_CONT_BIT = 5;
  localparam logic [4:0] CHAN_OFF = 5'h1F;
  localparam logic [7:0] CTRL1_RESET = 8'h1F;
  // Control 2 fields.
  localparam int CTRL2_ACT_BIT = 7;
  localparam int CTRL2_TRG_BIT = 6;
  localparam int CTRL2_CMPEN_BIT = 5;
  localparam int CTRL2_CMPGT_BIT = 4;
  // Config fields.
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_MODE_LSB = 2;
  localparam logic [1:0] MODE_8BIT = 2'h0;
  localparam logic [1:0] MODE_10BIT = 2'h2;
  localparam logic [1:0] SRC_BUS = 2'h0;
  localparam logic [1:0] SRC_BUS_HALF = 2'h1;
  localparam logic [1:0] SRC_ALT = 2'h2;
  localparam logic [1:0] SRC_ASYNC = 2'h3;
  // Converter clock ticks per conversion (successive approximation steps plus sample).
  localparam logic [5:0] CONV_TICKS_8 = 6'h14;
  localparam logic [5:0] CONV_TICKS_10 = 6'h17;
  // Terminal count of the free-running oscillator for the internal asynchronous clock (one tick every 4 bus cycles).
  localparam logic [2:0] ASYNC_OSC_DIV = 3'h3;
  typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_CONV, ST_DONE} aptc_state_e;
endpackage

// *** aptc_clkdiv.sv ***
// Converter clock enable generator: source select then power-of-two divider.
// Assumes all sources arrive as one-cycle enables on the bus clock.
`timescale 1ns/1ps
`default_nettype none
module aptc_clkdiv (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Control.
  input wire logic run_i,
  input wire logic [1:0] src_i,
  input wire logic [1:0] div_i,
  input wire logic alt_tick_i,
  input wire logic async_tick_i,
  // Converter clock enable.
  output logic tick_o
);
  logic half_reg;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  wire logic src_tick;
  wire logic [2:0] div_mask;
  assign src_tick = (src_i == aptc_pkg::SRC_BUS) ? 1'b1 : // [RULE18] [RULE10]
                    (src_i == aptc_pkg::SRC_BUS_HALF) ? half_reg : // [RULE12]
                    (src_i == aptc_pkg::SRC_ALT) ? alt_tick_i : async_tick_i;
  // Divide-select code n gives 2**n.
  assign div_mask = 3'((4'h1 << div_i) - 4'h1); // [RULE11] [RULE19]
  assign cnt_next = 3'(cnt_reg + 3'h1);
  assign tick_o = run_i && src_tick && ((cnt_reg & div_mask) == div_mask);
  always_ff @(posedge clk_i) begin
    if (reset_i || !run_i) begin
      half_reg <= 1'b0;
      cnt_reg <= 3'h0;
    end else begin
      half_reg <= ~half_reg;
      if (src_tick) begin
        cnt_reg <= cnt_next;
      end
    end
  end
endmodule
`default_nettype wire

// *** aptc_top_properties.sv ***
// Concurrent checks on the converter control block's ports.
// Assumes it is bound onto aptc_top, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module aptc_top_properties (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Bus.
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  // Pins.
  input wire logic [23:0] port_oe_n_i,
  input wire logic [23:0] port_pullup_i,
  input wire logic [23:0] pin_oe_n_o,
  input wire logic [23:0] pin_pullup_o,
  input wire logic [23:0] pin_ibuf_en_o,
  input wire logic [23:0] port_read_o,
  // Converter.
  input wire logic conv_enable_o,
  input wire logic sample_o,
  input wire logic async_osc_on_o,
  input wire logic [4:0] channel_select_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_oe; pin_oe_n_o == (port_oe_n_i | ~pin_ibuf_en_o); endproperty
  a_oe: assert property (p_oe) else $error("pin driver not released");
  property p_pu; pin_pullup_o == (port_pullup_i & pin_ibuf_en_o); endproperty
  a_pu: assert property (p_pu) else $error("pullup not cut");
  property p_rd; (port_read_o & ~pin_ibuf_en_o) == 24'h000000; endproperty
  a_rd: assert property (p_rd) else $error("disabled pin reads nonzero");
  property p_off; channel_select_o == 5'h1F |-> !conv_enable_o; endproperty
  a_off: assert property (p_off) else $error("converter on with channel off");
  property p_rst; $fell(reset_i) |-> !conv_enable_o && !irq_o && channel_select_o == 5'h1F; endproperty
  a_rst: assert property (p_rst) else $error("state after reset wrong");
  property p_wait; $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
  a_wait: assert property (p_wait) else $error("wait cycle count wrong");
  property p_osc; async_osc_on_o |-> conv_enable_o; endproperty
  a_osc: assert property (p_osc) else $error("oscillator on while idle");
  property p_ibuf; !$stable(pin_ibuf_en_o) |-> $past(avs_write_i && !avs_waitrequest_o); endproperty
  a_ibuf: assert property (p_ibuf) else $error("pin control changed without write");
  property p_pulse; sample_o |=> !sample_o; endproperty
  a_pulse: assert property (p_pulse) else $error("sample pulse too long");
  c_sample: cover property (sample_o);
  c_irq: cover property (irq_o);
  c_osc: cover property (async_osc_on_o);
endmodule
bind aptc_top aptc_top_properties u_props (.clk_i, .reset_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
  .port_oe_n_i, .port_pullup_i, .pin_oe_n_o, .pin_pullup_o, .pin_ibuf_en_o, .port_read_o,
  .conv_enable_o, .sample_o, .async_osc_on_o, .channel_select_o, .irq_o);
`default_nettype wire

// *** aptc_far_model.sv ***
// Far side: port logic, analog pins, analog core and trigger source.
// Assumes the bench sets the raw result and the trigger level.
`timescale 1ns/1ps
`default_nettype none
module aptc_far_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Bench commands.
  input wire logic [10:0] raw_i,
  input wire logic trig_i,
  // Toward the block.
  output logic [23:0] port_oe_n_o,
  output logic [23:0] port_pullup_o,
  output logic [23:0] pin_in_o,
  output logic [10:0] raw_result_o,
  output logic alt_tick_o,
  output logic hw_trigger_o
);
  logic [1:0] alt_cnt = 2'h0;
  logic trig_q = 1'b0;
  // Port logic drives every pin high with pullup on, so any masking shows.
  assign port_oe_n_o = 24'h000000;
  assign port_pullup_o = 24'hFFFFFF;
  assign pin_in_o = 24'hFFFFFF;
  assign raw_result_o = raw_i;
  assign alt_tick_o = alt_cnt == 2'h2;
  assign hw_trigger_o = trig_q;
  always @(posedge clk_i) begin
    alt_cnt <= (reset_i || alt_cnt == 2'h2) ? 2'h0 : alt_cnt + 2'h1;
  end
  // The trigger moves off the clock edge, as an unrelated source would.
  always @(negedge clk_i) begin
    trig_q <= trig_i;
  end
endmodule
`default_nettype wire

// *** aptc_top_tb_top.sv ***
// Bench for the converter control block: registers, pins, clocks, trigger.
// Assumes the far-side model and the checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module aptc_top_tb_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [10:0] raw_r = 11'h000;
  logic trig_r = 1'b0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, alt_tick_i, hw_trigger_input_i, conv_enable_o, sample_o, async_osc_on_o, irq_o;
  logic [23:0] port_oe_n_i, port_pullup_i, pin_in_i, pin_oe_n_o, pin_pullup_o, pin_ibuf_en_o, port_read_o;
  logic [10:0] raw_result_i;
  logic [4:0] channel_select_o;
  int error_cnt = 0;
  int checked = 0;
  always #25 clk_i = ~clk_i;
  aptc_top dut_u (.clk_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_readdata_o, .avs_waitrequest_o, .port_oe_n_i, .port_pullup_i, .pin_in_i, .pin_oe_n_o,
    .pin_pullup_o, .pin_ibuf_en_o, .port_read_o, .raw_result_i, .alt_tick_i, .hw_trigger_input_i,
    .conv_enable_o, .sample_o, .async_osc_on_o, .channel_select_o, .irq_o);
  aptc_far_model far_u (.clk_i, .reset_i, .raw_i(raw_r), .trig_i(trig_r), .port_oe_n_o(port_oe_n_i),
    .port_pullup_o(port_pullup_i), .pin_in_o(pin_in_i), .raw_result_o(raw_result_i),
    .alt_tick_o(alt_tick_i), .hw_trigger_o(hw_trigger_input_i));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {24'h0, d};
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    chk("wait edges", n, 2);
  endtask
  task automatic t_regs();
    logic [7:0] q;
    bus(0, aptc_pkg::IDX_CTRL1, 8'h00, q);
    chk("ctrl1 reset", q, aptc_pkg::CTRL1_RESET);
    bus(0, aptc_pkg::IDX_CFG, 8'h00, q);
    chk("cfg reset", q, 8'h00);
    bus(1, 4'hF, 8'hFF, q);
    bus(0, 4'hF, 8'h00, q);
    chk("unmapped", q, 8'h00);
  endtask
  task automatic t_pins();
    logic [7:0] q;
    logic [23:0] dis;
    logic [23:0] en;
    for (int g = 0; g < 3; g++) begin
      dis = 24'h0;
      dis[g*8 +: 8] = 8'h81 >> g;
      en = ~dis;
      bus(1, 4'(g), 8'h81 >> g, q);
      bus(0, 4'(g), 8'h00, q);
      chk("pin reg", q, 8'h81 >> g);
      repeat (3) @(posedge clk_i);
      chk("oe_n", pin_oe_n_o, dis);
      chk("pullup", pin_pullup_o, en);
      chk("ibuf", pin_ibuf_en_o, en);
      chk("port read", port_read_o, en);
      bus(1, 4'(g), 8'h00, q);
    end
  endtask
  function automatic logic [9:0] rnd(input logic ten, input logic [10:0] raw);
    logic [11:0] s;
    s = ten ? raw + 12'h1 : {3'h0, raw[8:0]} + 12'h1;
    s = s >> 1;
    if (ten && s > 12'h3FF) s = 12'h3FF;
    if (!ten && s > 12'h0FF) s = 12'h0FF;
    return s[9:0];
  endfunction
  task automatic t_conv(input logic [7:0] cfg, input logic [7:0] c1, input logic [10:0] raw, input int tk, input int per,
                        input logic [9:0] sub = 10'h000);
    logic [7:0] q;
    logic [9:0] r;
    int n;
    logic o;
    r = 10'(rnd(cfg[3], raw) - sub);
    n = 0;
    o = 1'b0;
    raw_r <= raw;
    bus(1, aptc_pkg::IDX_CFG, cfg, q);
    bus(1, aptc_pkg::IDX_CTRL1, c1, q);
    for (int w = 0; w < 2000 && sample_o !== 1'b1; w++) begin
      @(posedge clk_i);
      n += int'(conv_enable_o === 1'b1);
      o |= async_osc_on_o === 1'b1;
    end
    chk("conv length", n > tk*per - per && n <= tk*per + 8, 1);
    chk("oscillator", o, cfg[1:0] == 2'h3);
    repeat (3) @(posedge clk_i);
    chk("idle", conv_enable_o, 0);
    chk("irq", irq_o, c1[6]);
    bus(0, aptc_pkg::IDX_CTRL1, 8'h00, q);
    chk("done", q[7], 1);
    bus(0, aptc_pkg::IDX_RES_HI, 8'h00, q);
    chk("result high", q, {6'h0, r[9:8]});
    bus(0, aptc_pkg::IDX_RES_LO, 8'h00, q);
    chk("result low", q, r[7:0]);
    @(posedge clk_i);
    chk("irq clear", irq_o, 0);
  endtask
  task automatic t_clk();
    // Each divider keeps the converter clock at or below the bus rate.
    for (int d = 0; d < 4; d++) begin
      t_conv({1'b0, 2'(d), 5'h00}, {1'b0, 1'(d), 6'h04}, 11'h0AB, 20, 1 << d);
    end
    t_conv(8'h69, 8'h45, 11'h2AB, 23, 16);
    t_conv(8'h02, 8'h46, 11'h1FF, 20, 3);
    t_conv(8'h2B, 8'h07, 11'h7FF, 23, 8);
  endtask
  task automatic t_cmp();
    logic [7:0] q;
    bus(1, aptc_pkg::IDX_CMP_LO, 8'h50, q);
    bus(1, aptc_pkg::IDX_CTRL2, 8'h30, q);
    t_conv(8'h00, 8'h03, 11'h0AB, 20, 1, 10'h050);
    bus(1, aptc_pkg::IDX_CMP_LO, 8'h60, q);
    bus(1, aptc_pkg::IDX_CTRL1, 8'h03, q);
    repeat (30) @(posedge clk_i);
    bus(0, aptc_pkg::IDX_CTRL1, 8'h00, q);
    chk("compare miss flag", q[7], 0);
    bus(0, aptc_pkg::IDX_RES_LO, 8'h00, q);
    chk("compare miss result", q, 8'h06);
    bus(1, aptc_pkg::IDX_CTRL2, 8'h00, q);
  endtask
  task automatic t_off();
    logic [7:0] q;
    logic o;
    o = 1'b0;
    bus(1, aptc_pkg::IDX_CTRL1, 8'h1F, q);
    repeat (30) @(posedge clk_i) o |= conv_enable_o !== 1'b0;
    chk("off", o, 0);
    chk("channel", channel_select_o, 5'h1F);
  endtask
  task automatic t_trig();
    logic [7:0] q;
    int n;
    int s;
    n = 0;
    s = 0;
    bus(1, aptc_pkg::IDX_CFG, 8'h00, q);
    bus(1, aptc_pkg::IDX_CTRL2, 8'h40, q);
    bus(1, aptc_pkg::IDX_CTRL1, 8'h02, q);
    repeat (5) @(posedge clk_i);
    chk("soft start", conv_enable_o, 0);
    trig_r <= 1'b1;
    for (int w = 0; w < 80; w++) begin
      @(posedge clk_i);
      if (w == 8) chk("hw start", conv_enable_o, 1);
      if (w == 10) trig_r <= 1'b0;
      if (w == 12) trig_r <= 1'b1;
      if (sample_o === 1'b1) begin
        s++;
        n = w;
      end
    end
    chk("samples", s, 1);
    chk("first end", n < 32, 1);
    trig_r <= 1'b0;
    bus(1, aptc_pkg::IDX_CTRL1, 8'h22, q);
    s = 0;
    trig_r <= 1'b1;
    for (int w = 0; w < 100; w++) begin
      @(posedge clk_i);
      if (w == 30) trig_r <= 1'b0;
      if (w == 35) trig_r <= 1'b1;
      s += int'(sample_o === 1'b1);
    end
    chk("continuous samples", s, 4);
    bus(1, aptc_pkg::IDX_CTRL1, 8'h1F, q);
    trig_r <= 1'b0;
    bus(1, aptc_pkg::IDX_CTRL2, 8'h00, q);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_pins();
    t_clk();
    t_cmp();
    t_off();
    t_trig();
    final_report();
  end
  initial begin
    repeat (10000) @(posedge clk_i);
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
